// ==== hw/tlu_info_mem.sv ====
// Flip-flop store for the user information block
`timescale 1ns/1ps
module tlu_info_mem (
  // Clock
  input wire logic clk_i,
  // Access
  input wire logic we_i,
  input wire logic [tlu_pkg::INFO_IW-1:0] idx_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  typedef struct packed {
    logic [tlu_pkg::INFO_BYTES-1:0][7:0] mem;
  } tlu_mem_state_t;

  tlu_mem_state_t q, d;

  assign rdata_o = q.mem[idx_i];

  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[idx_i] = wdata_i;
    end
  end

  // Nonvolatile content: not cleared by reset
  always_ff @(posedge clk_i) begin
    q <= d;
  end

endmodule // tlu_info_mem

// ==== hw/tlu_pkg.sv ====
// Constants and types for the table-lookup access unit
package tlu_pkg;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_PTR_HI = 7'h1D;
  localparam logic [6:0] IDX_PTR_LO = 7'h1E;
  localparam logic [6:0] IDX_DATA = 7'h20;
  localparam logic [6:0] IDX_CTRL = 7'h5E;
  localparam int ADR_LO = 2;
  localparam int ADR_HI = 8;

  // Reset values
  localparam logic [7:0] RST_PTR_HI = 8'h00;
  localparam logic [7:0] RST_PTR_LO = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // Pointer-high fields
  localparam int CMD_WR_INC_BIT = 7;
  localparam int CMD_WR_BIT = 6;
  localparam int CMD_RD_INC_BIT = 5;
  localparam int CMD_RD_BIT = 4;
  localparam int CMD_LSB = 4;
  localparam int CMD_W = 4;
  localparam int PTR_HI_W = 4;

  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BLK_SEL_BIT = 6;

  // Pointer and memory geometry
  localparam int PTR_W = 12;
  localparam int PM_AW = 11;
  localparam int PM_DW = 16;
  localparam int INFO_BYTES = 111;
  localparam int INFO_IW = 7;
  localparam logic [7:0] INFO_FIRST = 8'h09;
  localparam logic [7:0] INFO_LAST = 8'h77;
  localparam logic [7:0] INFO_VOID = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_PM_WAIT
  } tlu_state_t;

endpackage

// ==== hw/tlu_reg_if.sv ====
// Register access carrier between bus slave and core
`timescale 1ns/1ps
interface tlu_reg_if;
  logic wr;
  logic [6:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bus (output wr, output idx, output wdata, input rdata);
  modport core (input wr, input idx, input wdata, output rdata);
endinterface

// ==== hw/tlu_top.sv ====
// Table-lookup unit: program memory and information block access
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps

// Contract
// - The information block holds 111 EEPROM bytes reached only here.
// - Bytes 00H-08H are reserved; user bytes sit at 09H up to 77H.
// - A write command stores the latch in the information block only; the increment form bumps it.
// - A read command loads the latch; the increment form bumps it.
// - The fetched byte is readable in the 8-bit data latch register.
// - Pointer bit 0 one gives the word's high byte, zero the low byte.
// - Word N maps to byte pointers 2N and 2N+1, up to word 7FF.
// - Pointer-high holds the four commands in 7-4, pointer 11-8 in 3-0.
// - Control bit 7 enables the lookup function when set.
// - Control bit 6 points lookups at program memory when set.
module tlu_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Program memory read port
  output logic [tlu_pkg::PM_AW-1:0] pm_addr_o,
  output logic pm_rd_o,
  input wire logic [tlu_pkg::PM_DW-1:0] pm_data_i,
  // Status
  output logic busy_o
);

  typedef struct packed {
    tlu_pkg::tlu_state_t st;
    logic [tlu_pkg::PTR_W-1:0] ptr;
    logic [tlu_pkg::CMD_W-1:0] cmd;
    logic [7:0] data;
    logic en;
    logic blk_sel;
    logic [tlu_pkg::PM_AW-1:0] pm_addr;
    logic pm_rd;
    logic busy;
  } tlu_core_state_t;

  tlu_core_state_t q, d;
  tlu_reg_if regs ();

  logic mem_we;
  logic [tlu_pkg::INFO_IW-1:0] mem_idx;
  logic [7:0] mem_rdata;
  logic info_ok;

  // Keep only the highest-priority command bit
  function automatic logic [tlu_pkg::CMD_W-1:0] pick_cmd(
    input logic [tlu_pkg::CMD_W-1:0] c
  );
    logic [tlu_pkg::CMD_W-1:0] r;
    r = '0;
    for (int i = tlu_pkg::CMD_W - 1; i >= 0; i--) begin
      if (c[i] && r == '0) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic cmd_bit(
    input logic [tlu_pkg::CMD_W-1:0] c,
    input int pos
  );
    return c[pos - tlu_pkg::CMD_LSB];
  endfunction

  function automatic logic is_write(input logic [tlu_pkg::CMD_W-1:0] c);
    return cmd_bit(c, tlu_pkg::CMD_WR_INC_BIT)
      | cmd_bit(c, tlu_pkg::CMD_WR_BIT);
  endfunction

  function automatic logic is_inc(input logic [tlu_pkg::CMD_W-1:0] c);
    return cmd_bit(c, tlu_pkg::CMD_WR_INC_BIT)
      | cmd_bit(c, tlu_pkg::CMD_RD_INC_BIT);
  endfunction

  // Register read view
  function automatic logic [7:0] reg_view(
    input logic [6:0] idx,
    input tlu_core_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    if (idx == tlu_pkg::IDX_PTR_HI) begin
      v = {s.cmd, s.ptr[tlu_pkg::PTR_W-1:tlu_pkg::PTR_W-tlu_pkg::PTR_HI_W]};
    end else if (idx == tlu_pkg::IDX_PTR_LO) begin
      v = s.ptr[7:0];
    end else if (idx == tlu_pkg::IDX_DATA) begin
      v = s.data;
    end else if (idx == tlu_pkg::IDX_CTRL) begin
      v[tlu_pkg::CTRL_EN_BIT] = s.en;
      v[tlu_pkg::CTRL_BLK_SEL_BIT] = s.blk_sel;
    end
    return v;
  endfunction

  tlu_wb_slave u_wb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i (we_i),
    .adr_i (adr_i),
    .sel_i (sel_i),
    .dat_i (dat_i),
    .dat_o (dat_o),
    .ack_o (ack_o),
    .regs (regs.bus)
  );

  tlu_info_mem u_mem (
    .clk_i (clk_i),
    .we_i (mem_we),
    .idx_i (mem_idx),
    .wdata_i (q.data),
    .rdata_o (mem_rdata)
  );

  assign regs.rdata = reg_view(regs.idx, q);

  // Only 09H..77H with zero upper bits reach storage
  assign info_ok = (q.ptr[tlu_pkg::PTR_W-1:8] == '0)
    && (q.ptr[7:0] >= tlu_pkg::INFO_FIRST)
    && (q.ptr[7:0] <= tlu_pkg::INFO_LAST);
  assign mem_idx = info_ok
    ? tlu_pkg::INFO_IW'(q.ptr[7:0] - tlu_pkg::INFO_FIRST)
    : '0;
  assign mem_we = (q.st == tlu_pkg::ST_EXEC) && !q.blk_sel
    && is_write(q.cmd) && info_ok;

  assign pm_addr_o = q.pm_addr;
  assign pm_rd_o = q.pm_rd;
  assign busy_o = q.busy;

  always_comb begin
    d = q;
    d.pm_rd = 1'b0;

    // Register writes, ignored while an access runs
    if (regs.wr && q.st == tlu_pkg::ST_IDLE) begin
      if (regs.idx == tlu_pkg::IDX_PTR_HI) begin
        d.ptr[tlu_pkg::PTR_W-1:tlu_pkg::PTR_W-tlu_pkg::PTR_HI_W] =
          regs.wdata[tlu_pkg::PTR_HI_W-1:0];
        if (q.en) begin
          d.cmd = pick_cmd(regs.wdata[7:tlu_pkg::CMD_LSB]);
        end
      end else if (regs.idx == tlu_pkg::IDX_PTR_LO) begin
        d.ptr[7:0] = regs.wdata;
      end else if (regs.idx == tlu_pkg::IDX_DATA) begin
        d.data = regs.wdata;
      end else if (regs.idx == tlu_pkg::IDX_CTRL) begin
        d.en = regs.wdata[tlu_pkg::CTRL_EN_BIT];
        d.blk_sel = regs.wdata[tlu_pkg::CTRL_BLK_SEL_BIT];
      end
    end

    case (q.st)
      tlu_pkg::ST_IDLE: begin
        if (q.cmd != '0) begin
          d.st = tlu_pkg::ST_EXEC;
          d.busy = 1'b1;
        end
      end
      tlu_pkg::ST_EXEC: begin
        if (q.blk_sel && !is_write(q.cmd)) begin
          // Byte pointer to word address
          d.pm_addr = q.ptr[tlu_pkg::PTR_W-1:1];
          d.pm_rd = 1'b1;
          d.st = tlu_pkg::ST_PM_WAIT;
        end else begin
          if (!q.blk_sel && !is_write(q.cmd)) begin
            d.data = info_ok ? mem_rdata : tlu_pkg::INFO_VOID;
          end
          // Program memory is not writable here
          if (is_inc(q.cmd)) begin
            d.ptr = q.ptr + tlu_pkg::PTR_W'(1);
          end
          d.cmd = '0;
          d.busy = 1'b0;
          d.st = tlu_pkg::ST_IDLE;
        end
      end
      tlu_pkg::ST_PM_WAIT: begin
        d.data = q.ptr[0] ? pm_data_i[tlu_pkg::PM_DW-1:8]
          : pm_data_i[7:0];
        if (is_inc(q.cmd)) begin
          d.ptr = q.ptr + tlu_pkg::PTR_W'(1);
        end
        d.cmd = '0;
        d.busy = 1'b0;
        d.st = tlu_pkg::ST_IDLE;
      end
      default: begin
        d.st = tlu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.st <= tlu_pkg::ST_IDLE;
      q.ptr <= {tlu_pkg::RST_PTR_HI[tlu_pkg::PTR_HI_W-1:0],
        tlu_pkg::RST_PTR_LO};
      q.cmd <= tlu_pkg::RST_PTR_HI[7:tlu_pkg::CMD_LSB];
      q.data <= tlu_pkg::RST_DATA;
      q.en <= tlu_pkg::RST_CTRL[tlu_pkg::CTRL_EN_BIT];
      q.blk_sel <= tlu_pkg::RST_CTRL[tlu_pkg::CTRL_BLK_SEL_BIT];
      q.pm_addr <= '0;
      q.pm_rd <= 1'b0;
      q.busy <= 1'b0;
    end else begin
      q <= d;
    end
  end

endmodule // tlu_top

// ==== hw/tlu_wb_slave.sv ====
// Classic Wishbone slave front end for the lookup registers
`timescale 1ns/1ps
module tlu_wb_slave (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Register carrier
  tlu_reg_if.bus regs
);

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
  } tlu_wb_state_t;

  tlu_wb_state_t q, d;
  logic req;

  assign req = cyc_i & stb_i;
  assign regs.idx = adr_i[tlu_pkg::ADR_HI:tlu_pkg::ADR_LO];
  assign regs.wdata = dat_i[7:0];
  // Write lands on the edge that samples ack
  assign regs.wr = req & we_i & q.ack & sel_i[0];
  assign dat_o = {24'h000000, q.dat};
  assign ack_o = q.ack;

  always_comb begin
    d = q;
    d.ack = req & ~q.ack;
    if (d.ack) begin
      d.dat = we_i ? 8'h00 : regs.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // tlu_wb_slave

// ==== tb/tlu_checker.sv ====
// Port assertions for the table-lookup unit
`timescale 1ns/1ps
module tlu_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Program memory and status
  input wire logic [10:0] pm_addr_o,
  input wire logic pm_rd_o,
  input wire logic [15:0] pm_data_i,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cmd_w;
  // Accepted write of command bits into pointer high
  assign cmd_w = ack_o && we_i && sel_i[0] && adr_i[8:2] == 7'h1D
    && dat_i[7:4] != 4'h0;
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_pm_end; busy_o ##1 !busy_o; endsequence
  property p_ack; s_req |=> ack_o; endproperty
  property p_ack_one; ack_o |=> !ack_o; endproperty
  property p_ack_src; ack_o |-> $past(cyc_i && stb_i); endproperty
  property p_upper; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  // Busy rises two edges after the command write is acked
  property p_busy_src;
    !busy_o && !cmd_w && !$past(cmd_w) |=> !busy_o;
  endproperty
  property p_busy_len; $rose(busy_o) |-> ##[1:2] !busy_o; endproperty
  property p_pm_one; pm_rd_o |=> !pm_rd_o; endproperty
  property p_pm_end; pm_rd_o |-> s_pm_end; endproperty
  property p_pm_hold; !pm_rd_o |-> $stable(pm_addr_o); endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  a_ack_src: assert property (p_ack_src) else $error("stray ack");
  a_upper: assert property (p_upper) else $error("upper data");
  a_busy_src: assert property (p_busy_src) else $error("stray busy");
  a_busy_len: assert property (p_busy_len) else $error("busy long");
  a_pm_one: assert property (p_pm_one) else $error("long strobe");
  a_pm_end: assert property (p_pm_end) else $error("pm end");
  a_pm_hold: assert property (p_pm_hold) else $error("pm addr");
endmodule // tlu_checker

bind tlu_top tlu_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .pm_addr_o, .pm_rd_o, .pm_data_i, .busy_o);

// ==== tb/tlu_pm_model.sv ====
// Synchronous program memory model with a fixed word pattern
`timescale 1ns/1ps
module tlu_pm_model (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic pm_rd_i,
  input wire logic [10:0] pm_addr_i,
  output logic [15:0] pm_data_o
);
  logic hold_q;
  logic [15:0] last_q;
  logic [15:0] word;
  // Both bytes of every word differ
  assign word = {5'h00, pm_addr_i} ^ {pm_addr_i[7:0], 8'hC3};
  // Word valid in strobe cycle and the next, then scrambled
  assign pm_data_o = pm_rd_i ? word : (hold_q ? last_q : ~last_q);
  always_ff @(posedge clk_i) begin
    hold_q <= pm_rd_i;
    if (pm_rd_i) begin
      last_q <= word;
    end
  end
endmodule // tlu_pm_model

// ==== tb/tlu_top_test.sv ====
// Self-checking bench for the table-lookup unit
`timescale 1ns/1ps
`define CHK(g, e) chk8(g, e)
module tlu_top_test;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [31:0] adr_i = 0, dat_i = 0, dat_o;
  logic [3:0] sel_i = 0;
  logic ack_o, pm_rd_o, busy_o;
  logic [10:0] pm_addr_o;
  logic [15:0] pm_data_i;
  logic [7:0] r;
  logic [11:0] p;
  logic [7:0] mem [0:4];
  logic [11:0] pts [0:4] = '{12'hFFE, 12'hFFF, 12'h000, 12'h001, 12'hF41};
  int bad_count = 0, num_checks = 0, seed = 55;
  tlu_top uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .pm_addr_o, .pm_rd_o, .pm_data_i, .busy_o);
  tlu_pm_model pm (.clk_i, .pm_rd_i(pm_rd_o), .pm_addr_i(pm_addr_o),
    .pm_data_o(pm_data_i));
  initial forever #25 clk_i = ~clk_i;
  task chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [6:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
    adr_i <= {23'h0, i, 2'h0};
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    r = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task cmd(input logic [7:0] c);
    int n;
    wb(1, tlu_pkg::IDX_PTR_HI, c);
    n = 0;
    repeat (2) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) bad_count++;
  endtask
  task ptr(input logic [11:0] a);
    wb(1, tlu_pkg::IDX_PTR_LO, a[7:0]);
    wb(1, tlu_pkg::IDX_PTR_HI, {4'h0, a[11:8]});
  endtask
  task rd(input logic [6:0] i);
    wb(0, i, 8'h00);
  endtask
  function automatic logic [7:0] pm_byte(input logic [11:0] q);
    logic [10:0] w;
    w = q[11:1];
    return q[0] ? (w[7:0] ^ {5'h00, w[10:8]}) : (w[7:0] ^ 8'hC3);
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 8000);
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(tlu_pkg::IDX_PTR_HI); `CHK(r, tlu_pkg::RST_PTR_HI);
    rd(tlu_pkg::IDX_PTR_LO); `CHK(r, tlu_pkg::RST_PTR_LO);
    rd(tlu_pkg::IDX_DATA); `CHK(r, tlu_pkg::RST_DATA);
    rd(tlu_pkg::IDX_CTRL); `CHK(r, tlu_pkg::RST_CTRL);
    rd(7'h01); `CHK(r, 8'h00);
    // Disabled unit leaves the latch alone
    wb(1, tlu_pkg::IDX_DATA, 8'h5A);
    cmd(8'h10);
    rd(tlu_pkg::IDX_DATA); `CHK(r, 8'h5A);
    wb(1, tlu_pkg::IDX_CTRL, 8'h80);
    rd(tlu_pkg::IDX_CTRL); `CHK(r, 8'h80);
    ptr(12'h009);
    for (int k = 0; k < 4; k++) begin
      mem[k] = 8'($random(seed));
      wb(1, tlu_pkg::IDX_DATA, mem[k]);
      cmd(8'h80);
    end
    rd(tlu_pkg::IDX_PTR_LO); `CHK(r, 8'h0D);
    rd(tlu_pkg::IDX_PTR_HI); `CHK(r, 8'h00);
    mem[4] = 8'($random(seed));
    ptr(12'h077);
    wb(1, tlu_pkg::IDX_DATA, mem[4]);
    cmd(8'h40);
    rd(tlu_pkg::IDX_PTR_LO); `CHK(r, 8'h77);
    // Reserved byte stays unwritable
    ptr(12'h005);
    wb(1, tlu_pkg::IDX_DATA, 8'hFF);
    cmd(8'h40);
    cmd(8'h10);
    rd(tlu_pkg::IDX_DATA); `CHK(r, 8'h00);
    ptr(12'h009);
    for (int k = 0; k < 4; k++) begin
      cmd(8'h20);
      rd(tlu_pkg::IDX_DATA); `CHK(r, mem[k]);
    end
    ptr(12'h077);
    cmd(8'h10);
    rd(tlu_pkg::IDX_DATA); `CHK(r, mem[4]);
    ptr(12'h078);
    cmd(8'h10);
    rd(tlu_pkg::IDX_DATA); `CHK(r, 8'h00);
    // Program memory: corners, worked example, random pointers
    wb(1, tlu_pkg::IDX_CTRL, 8'hC0);
    for (int k = 0; k < 9; k++) begin
      p = (k < 5) ? pts[k] : 12'($random(seed));
      ptr(p);
      cmd({4'h1, p[11:8]});
      rd(tlu_pkg::IDX_DATA); `CHK(r, pm_byte(p));
    end
    // Incrementing read wraps the pointer
    ptr(12'hFFF);
    cmd(8'h2F);
    rd(tlu_pkg::IDX_DATA); `CHK(r, pm_byte(12'hFFF));
    rd(tlu_pkg::IDX_PTR_LO); `CHK(r, 8'h00);
    rd(tlu_pkg::IDX_PTR_HI); `CHK(r, 8'h00);
    finish_test;
  end
endmodule // tlu_top_test
